// [core/uefr_pkg.sv]
// Package of register indices, reset values and field positions for the enhanced UART control
// Summary of operation
// - Gated enhanced bits and trigger/fraction registers accept writes only when enable bit set
// - Clearing the enable bit freezes gated bits; writes ignored until set again
// - Reset clears gated enhanced bits and fractional divisor to zero
// - Special detect compares each received character to second stop character; match sets flag
// - First pair compare mode runs flow control and special detect independently
// - Second pair mode with special detect on: matching stop character skips FIFO, raises stop and special interrupts
// - Auto RTS drives RTS high at halt level; trigger interrupt fires at its own trigger level, auto RTS on or off
// - Auto RTS drives RTS low again once fill falls below resume level
// - Without auto RTS, the RTS pin follows the modem control bit only
// - Auto CTS stops new characters while CTS high, resumes when low
// - Four readable writable resume and stop character registers
// - Power-up loads divisor high byte 0x00 and low byte 0x01
// - Reset clears modem status change bits; upper bits show inverted modem inputs
// - Divisor high and low bytes, scratch and character registers initialise only at power-up; the fractional divisor clears on every reset
// - Writing one to software reset bit resets the device, then clears itself
package uefr_pkg;
  // Register indices on the host port
  localparam logic [4:0] IDX_RHR_THR = 5'h00;
  localparam logic [4:0] IDX_IER = 5'h01;
  localparam logic [4:0] IDX_FCR = 5'h02;
  localparam logic [4:0] IDX_ISR = 5'h03;
  localparam logic [4:0] IDX_LCR = 5'h04;
  localparam logic [4:0] IDX_MCR = 5'h05;
  localparam logic [4:0] IDX_LSR = 5'h06;
  localparam logic [4:0] IDX_MSR = 5'h07;
  localparam logic [4:0] IDX_SPR = 5'h08;
  localparam logic [4:0] IDX_TCR = 5'h09;
  localparam logic [4:0] IDX_TLR = 5'h0a;
  localparam logic [4:0] IDX_TXLV = 5'h0b;
  localparam logic [4:0] IDX_RXLV = 5'h0c;
  localparam logic [4:0] IDX_GPIO_DIRECTION = 5'h0d;
  localparam logic [4:0] IDX_IOST = 5'h0e;
  localparam logic [4:0] IDX_IOIE = 5'h0f;
  localparam logic [4:0] IDX_IOCTL = 5'h10;
  localparam logic [4:0] IDX_EXTRA_FEATURE_CONTROL = 5'h11;
  localparam logic [4:0] IDX_DLL = 5'h12;
  localparam logic [4:0] IDX_DLM = 5'h13;
  localparam logic [4:0] IDX_DLD = 5'h14;
  localparam logic [4:0] IDX_EFR = 5'h15;
  localparam logic [4:0] IDX_RES1 = 5'h16;
  localparam logic [4:0] IDX_RES2 = 5'h17;
  localparam logic [4:0] IDX_STOP1 = 5'h18;
  localparam logic [4:0] IDX_STOP2 = 5'h19;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DLL = 8'h01;
  localparam logic [7:0] RST_DLM = 8'h00;
  localparam logic [7:0] RST_SPR = 8'hff;
  localparam logic [7:0] RST_ISR = 8'h01;
  localparam logic [7:0] RST_LCR = 8'h1d;
  localparam logic [7:0] RST_TCR = 8'h0f;
  localparam logic [7:0] RST_CHAR = 8'h00;
  // Gated field masks
  localparam logic [7:0] IER_GATED = 8'hf0;
  localparam logic [7:0] FCR_GATED = 8'h30;
  localparam logic [7:0] MCR_GATED = 8'he4;
  // Field positions
  localparam int EFR_ENH = 4;
  localparam int EFR_SPEC = 5;
  localparam int EFR_ARTS = 6;
  localparam int EFR_ACTS = 7;
  localparam int IER_RXD = 0;
  localparam int IER_SPEC = 5;
  localparam int MCR_RTS = 1;
  localparam int MCR_DTR = 0;
  localparam int IOC_SWRST = 3;
  localparam int ISR_SPEC = 4;
  localparam int ISR_STOP = 5;
  localparam logic [1:0] RXFC_PAIR1 = 2'b10;
  localparam logic [1:0] RXFC_PAIR2 = 2'b01;
  // Level granularity of the halt, resume and trigger nibbles
  localparam logic [1:0] LVL_LSB = 2'b00;
  localparam logic [6:0] RX_TRIG_DEFAULT = 7'h08;
endpackage

// [core/uefr_core.sv]
// Enhanced feature control, flow control and reset-state logic of the UART
`timescale 1ns/1ps
`default_nettype none
module uefr_core
  import uefr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic reset_pin_n_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [7:0] rhr_data_i,
  input wire logic [7:0] lsr_i,
  input wire logic [7:0] tx_space_i,
  input wire logic [6:0] rx_fill_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic rx_push_o,
  output logic [7:0] rx_push_data_o,
  output logic thr_wr_o,
  output logic [7:0] thr_data_o,
  input wire logic tx_shift_busy_i,
  output logic tx_start_ok_o,
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  input wire logic ri_n_i,
  input wire logic cd_n_i,
  output logic rts_n_o,
  output logic dtr_n_o,
  output logic irq_n_o,
  output logic dev_reset_o,
  output logic [7:0] dl_low_o,
  output logic [7:0] dl_high_o,
  output logic [7:0] dl_frac_o,
  output logic [7:0] lcr_o,
  output logic [7:0] fcr_o,
  output logic [7:0] extra_feature_control_o,
  output logic [7:0] gpio_dir_o,
  output logic [7:0] gpio_out_o
);

  // Power-up reset release, two stages
  logic por_s1_q, por_n_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      por_s1_q <= 1'b0;
      por_n_q <= 1'b0;
    end else begin
      por_s1_q <= 1'b1;
      por_n_q <= por_s1_q;
    end
  end

  // Reset pin and modem inputs cross in through two flops
  logic [4:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge clk_i or negedge por_n_q) begin
    if (!por_n_q) begin
      pin_s1_q <= 5'h1f;
      pin_s2_q <= 5'h1f;
    end else begin
      pin_s1_q <= {reset_pin_n_i, cts_n_i, dsr_n_i, ri_n_i, cd_n_i};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic rpin_n, cts_n;
  logic [3:0] modem_n;
  assign rpin_n = pin_s2_q[4];
  assign cts_n = pin_s2_q[3];
  assign modem_n = pin_s2_q[3:0];

  // Software reset pulse; clears itself the cycle after it fires
  logic swrst_q;
  logic dev_rst;
  logic wr_en;
  assign dev_rst = !rpin_n || swrst_q;
  assign dev_reset_o = dev_rst;
  assign wr_en = reg_wr_i && !dev_rst;
  always_ff @(posedge clk_i or negedge por_n_q) begin
    if (!por_n_q) begin
      swrst_q <= 1'b0;
    end else begin
      swrst_q <= wr_en && reg_addr_i == IDX_IOCTL && reg_wdata_i[IOC_SWRST];
    end
  end

  // Registers kept across pin and software reset
  logic [7:0] dll_q, dlm_q, spr_q, res1_q, res2_q, stop1_q, stop2_q;
  always_ff @(posedge clk_i or negedge por_n_q) begin
    if (!por_n_q) begin
      dll_q <= RST_DLL;
      dlm_q <= RST_DLM;
      spr_q <= RST_SPR;
      res1_q <= RST_CHAR;
      res2_q <= RST_CHAR;
      stop1_q <= RST_CHAR;
      stop2_q <= RST_CHAR;
    end else if (wr_en) begin
      unique case (reg_addr_i)
        IDX_DLL: dll_q <= reg_wdata_i;
        IDX_DLM: dlm_q <= reg_wdata_i;
        IDX_SPR: spr_q <= reg_wdata_i;
        IDX_RES1: res1_q <= reg_wdata_i;
        IDX_RES2: res2_q <= reg_wdata_i;
        IDX_STOP1: stop1_q <= reg_wdata_i;
        IDX_STOP2: stop2_q <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Plain control registers, reset by every kind of reset (LCR to 0x1d, the others to zero)
  logic [7:0] efr_q, lcr_q, extra_feature_control_q, gpio_direction_q, iost_q, ioie_q, ioctl_q;
  always_ff @(posedge clk_i or negedge por_n_q) begin
    if (!por_n_q) begin
      efr_q <= RST_ZERO;
      lcr_q <= RST_LCR;
      extra_feature_control_q <= RST_ZERO;
      gpio_direction_q <= RST_ZERO;
      iost_q <= RST_ZERO;
      ioie_q <= RST_ZERO;
      ioctl_q <= RST_ZERO;
    end else if (dev_rst) begin
      efr_q <= RST_ZERO;
      lcr_q <= RST_LCR;
      extra_feature_control_q <= RST_ZERO;
      gpio_direction_q <= RST_ZERO;
      iost_q <= RST_ZERO;
      ioie_q <= RST_ZERO;
      ioctl_q <= RST_ZERO;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        IDX_EFR: efr_q <= reg_wdata_i;
        IDX_LCR: lcr_q <= reg_wdata_i;
        IDX_EXTRA_FEATURE_CONTROL: extra_feature_control_q <= reg_wdata_i;
        IDX_GPIO_DIRECTION: gpio_direction_q <= reg_wdata_i;
        IDX_IOST: iost_q <= reg_wdata_i;
        IDX_IOIE: ioie_q <= reg_wdata_i;
        // Reset bit is never stored; it reads back as zero
        IDX_IOCTL: ioctl_q <= reg_wdata_i & ~(8'h01 << IOC_SWRST);
        default: ;
      endcase
    end
  end

  // Registers whose enhanced bits are gated by the enhanced enable
  logic enh;
  logic [7:0] ier_q, fcr_q, mcr_q, tcr_q, tlr_q, dld_q;
  assign enh = efr_q[EFR_ENH];
  always_ff @(posedge clk_i or negedge por_n_q) begin
    if (!por_n_q) begin
      ier_q <= RST_ZERO;
      fcr_q <= RST_ZERO;
      mcr_q <= RST_ZERO;
      tcr_q <= RST_TCR;
      tlr_q <= RST_ZERO;
      dld_q <= RST_ZERO;
    end else if (dev_rst) begin
      ier_q <= RST_ZERO;
      fcr_q <= RST_ZERO;
      mcr_q <= RST_ZERO;
      tcr_q <= RST_TCR;
      tlr_q <= RST_ZERO;
      dld_q <= RST_ZERO;
    end else if (reg_wr_i) begin
      // Frozen fields keep their old bits while the enable is low
      unique case (reg_addr_i)
        IDX_IER: ier_q <= enh ? reg_wdata_i : ((ier_q & IER_GATED) | (reg_wdata_i & ~IER_GATED));
        IDX_FCR: fcr_q <= enh ? reg_wdata_i : ((fcr_q & FCR_GATED) | (reg_wdata_i & ~FCR_GATED));
        IDX_MCR: mcr_q <= enh ? reg_wdata_i : ((mcr_q & MCR_GATED) | (reg_wdata_i & ~MCR_GATED));
        IDX_TCR: if (enh) tcr_q <= reg_wdata_i;
        IDX_TLR: if (enh) tlr_q <= reg_wdata_i;
        IDX_DLD: if (enh) dld_q <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Receive path: special-character detect and flow-control compare
  logic spec_en, match_stop2, match_stop1, match_res1, match_res2;
  logic [1:0] rxfc;
  logic swallow;
  assign spec_en = efr_q[EFR_SPEC];
  assign rxfc = efr_q[1:0];
  assign match_stop2 = rx_data_i == stop2_q;
  assign match_stop1 = rx_data_i == stop1_q;
  assign match_res1 = rx_data_i == res1_q;
  assign match_res2 = rx_data_i == res2_q;
  // Only pair-two mode with detect on keeps the stop character out of the FIFO
  assign swallow = spec_en && rxfc == RXFC_PAIR2 && match_stop2;

  always_ff @(posedge clk_i or negedge por_n_q) begin
    if (!por_n_q) begin
      rx_push_o <= 1'b0;
      rx_push_data_o <= RST_ZERO;
    end else if (dev_rst) begin
      rx_push_o <= 1'b0;
      rx_push_data_o <= RST_ZERO;
    end else begin
      rx_push_o <= rx_valid_i && !swallow;
      if (rx_valid_i) begin
        rx_push_data_o <= rx_data_i;
      end
    end
  end

  // Status flags; a new event in the clearing cycle wins
  logic spec_q, stop_q, xoff_rx_q;
  logic spec_set, stop_set, isr_clr_rd;
  logic isr_wclr_spec, isr_wclr_stop;
  assign spec_set = rx_valid_i && spec_en && match_stop2;
  assign stop_set = rx_valid_i && ((rxfc == RXFC_PAIR1 && match_stop1) ||
                                   (rxfc == RXFC_PAIR2 && match_stop2));
  assign isr_clr_rd = reg_rd_i && reg_addr_i == IDX_ISR;
  // Direct clearing of the upper status bits needs the enhanced enable
  assign isr_wclr_spec = reg_wr_i && reg_addr_i == IDX_ISR && enh && reg_wdata_i[ISR_SPEC];
  assign isr_wclr_stop = reg_wr_i && reg_addr_i == IDX_ISR && enh && reg_wdata_i[ISR_STOP];
  always_ff @(posedge clk_i or negedge por_n_q) begin
    if (!por_n_q) begin
      spec_q <= 1'b0;
      stop_q <= 1'b0;
    end else if (dev_rst) begin
      spec_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      spec_q <= spec_set || (spec_q && !isr_clr_rd && !isr_wclr_spec);
      stop_q <= stop_set || (stop_q && !isr_clr_rd && !isr_wclr_stop);
    end
  end

  // Remote stop/resume state, kept for the transmit gate
  logic xoff_set, xon_set;
  assign xoff_set = stop_set;
  assign xon_set = rx_valid_i && ((rxfc == RXFC_PAIR1 && match_res1) ||
                                  (rxfc == RXFC_PAIR2 && match_res2));
  always_ff @(posedge clk_i or negedge por_n_q) begin
    if (!por_n_q) begin
      xoff_rx_q <= 1'b0;
    end else if (dev_rst || rxfc == 2'b00) begin
      xoff_rx_q <= 1'b0;
    end else if (xoff_set) begin
      xoff_rx_q <= 1'b1;
    end else if (xon_set) begin
      xoff_rx_q <= 1'b0;
    end
  end

  // Auto RTS thresholds in units of four characters
  logic [6:0] halt_lvl, resume_lvl, trig_lvl;
  logic rts_halt_q, rx_trig;
  assign halt_lvl = {1'b0, tcr_q[3:0], LVL_LSB};
  assign resume_lvl = {1'b0, tcr_q[7:4], LVL_LSB};
  assign trig_lvl = (tlr_q[7:4] != 4'h0) ? {1'b0, tlr_q[7:4], LVL_LSB} : RX_TRIG_DEFAULT;
  assign rx_trig = rx_fill_i >= trig_lvl;
  always_ff @(posedge clk_i or negedge por_n_q) begin
    if (!por_n_q) begin
      rts_halt_q <= 1'b0;
    end else if (dev_rst || !efr_q[EFR_ARTS]) begin
      rts_halt_q <= 1'b0;
    end else if (rx_fill_i >= halt_lvl) begin
      rts_halt_q <= 1'b1;
    end else if (rx_fill_i < resume_lvl) begin
      rts_halt_q <= 1'b0;
    end
  end

  // Modem pins; RTS high at reset because the control bit is clear
  always_ff @(posedge clk_i or negedge por_n_q) begin
    if (!por_n_q) begin
      rts_n_o <= 1'b1;
      dtr_n_o <= 1'b1;
    end else begin
      // Auto halt can only raise a line software already pulled low
      rts_n_o <= !mcr_q[MCR_RTS] || (efr_q[EFR_ARTS] && rts_halt_q);
      dtr_n_o <= !mcr_q[MCR_DTR];
    end
  end

  // Auto CTS gates only the start of a new character
  assign tx_start_ok_o = !(efr_q[EFR_ACTS] && cts_n) && !xoff_rx_q && !tx_shift_busy_i;

  // Modem status: change bits plus inverted live levels
  logic [3:0] modem_prev_q, msr_delta_q;
  logic msr_rd;
  logic [2:0] prime_q;
  assign msr_rd = reg_rd_i && reg_addr_i == IDX_MSR;
  // Synchroniser priming; its reset level is not the pins' level, so no false change
  always_ff @(posedge clk_i or negedge por_n_q) begin
    if (!por_n_q) begin
      prime_q <= 3'h0;
    end else begin
      prime_q <= {prime_q[1:0], 1'b1};
    end
  end
  always_ff @(posedge clk_i or negedge por_n_q) begin
    if (!por_n_q) begin
      modem_prev_q <= 4'hf;
      msr_delta_q <= 4'h0;
    end else if (dev_rst || !prime_q[2]) begin
      modem_prev_q <= modem_n;
      msr_delta_q <= 4'h0;
    end else begin
      modem_prev_q <= modem_n;
      msr_delta_q <= (modem_prev_q ^ modem_n) | (msr_rd ? 4'h0 : msr_delta_q);
    end
  end

  // Interrupt line; the status code bit 0 reads one when idle
  logic spec_irq, any_irq;
  assign spec_irq = (spec_q || stop_q) && ier_q[IER_SPEC];
  assign any_irq = spec_irq || (rx_trig && ier_q[IER_RXD]);
  always_ff @(posedge clk_i or negedge por_n_q) begin
    if (!por_n_q) begin
      irq_n_o <= 1'b1;
    end else if (dev_rst) begin
      irq_n_o <= 1'b1;
    end else begin
      irq_n_o <= !any_irq;
    end
  end

  // Transmit holding write strobe
  always_ff @(posedge clk_i or negedge por_n_q) begin
    if (!por_n_q) begin
      thr_wr_o <= 1'b0;
      thr_data_o <= RST_ZERO;
    end else begin
      thr_wr_o <= wr_en && reg_addr_i == IDX_RHR_THR;
      if (wr_en && reg_addr_i == IDX_RHR_THR) begin
        thr_data_o <= reg_wdata_i;
      end
    end
  end

  // Read mux, registered; write-only and unmapped indices read zero
  logic [7:0] isr_val, rd_d;
  assign isr_val = {2'b00, stop_q, spec_q, 3'b000, !any_irq} | (RST_ISR & 8'h00);
  always_comb begin
    rd_d = RST_ZERO;
    unique case (reg_addr_i)
      IDX_RHR_THR: rd_d = rhr_data_i;
      IDX_IER: rd_d = ier_q;
      IDX_ISR: rd_d = isr_val;
      IDX_LCR: rd_d = lcr_q;
      IDX_MCR: rd_d = mcr_q;
      IDX_LSR: rd_d = lsr_i;
      IDX_MSR: rd_d = {~modem_n, msr_delta_q};
      IDX_SPR: rd_d = spr_q;
      IDX_TCR: rd_d = tcr_q;
      IDX_TLR: rd_d = tlr_q;
      IDX_TXLV: rd_d = tx_space_i;
      IDX_RXLV: rd_d = {1'b0, rx_fill_i};
      IDX_GPIO_DIRECTION: rd_d = gpio_direction_q;
      IDX_IOST: rd_d = iost_q;
      IDX_IOIE: rd_d = ioie_q;
      IDX_IOCTL: rd_d = ioctl_q;
      IDX_EXTRA_FEATURE_CONTROL: rd_d = extra_feature_control_q;
      IDX_DLL: rd_d = dll_q;
      IDX_DLM: rd_d = dlm_q;
      IDX_DLD: rd_d = dld_q;
      IDX_EFR: rd_d = efr_q;
      IDX_RES1: rd_d = res1_q;
      IDX_RES2: rd_d = res2_q;
      IDX_STOP1: rd_d = stop1_q;
      IDX_STOP2: rd_d = stop2_q;
      default: rd_d = RST_ZERO;
    endcase
  end
  always_ff @(posedge clk_i or negedge por_n_q) begin
    if (!por_n_q) begin
      reg_rdata_o <= RST_ZERO;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_d;
    end
  end

  // Configuration outputs for baud, FIFO and GPIO blocks
  assign dl_low_o = dll_q;
  assign dl_high_o = dlm_q;
  assign dl_frac_o = dld_q;
  assign lcr_o = lcr_q;
  assign fcr_o = fcr_q;
  assign extra_feature_control_o = extra_feature_control_q;
  assign gpio_dir_o = gpio_direction_q;
  assign gpio_out_o = iost_q;

endmodule
`default_nettype wire

// [verification/uefr_core_asserts.sv]
// Checker of reset state, receive push, flow control and reset side effects
`timescale 1ns/1ps
`default_nettype none
module uefr_core_asserts
  import uefr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic reset_pin_n_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_push_o,
  input wire logic [7:0] rx_push_data_o,
  input wire logic tx_shift_busy_i,
  input wire logic tx_start_ok_o,
  input wire logic rts_n_o,
  input wire logic dtr_n_o,
  input wire logic irq_n_o,
  input wire logic dev_reset_o,
  input wire logic [7:0] dl_low_o,
  input wire logic [7:0] dl_high_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Writes only count once the internal reset copy and the pin reset are long gone
  sequence swrst_write;
    reg_wr_i && reg_addr_i == IDX_IOCTL && reg_wdata_i[IOC_SWRST] && !dev_reset_o
      && $past(rstn_i, 3) && reset_pin_n_i && $past(reset_pin_n_i) && $past(reset_pin_n_i, 2);
  endsequence
  sequence dtr_write;
    reg_wr_i && reg_addr_i == IDX_MCR && reg_wdata_i[MCR_DTR] && !dev_reset_o && $past(rstn_i, 3);
  endsequence
  sequence reset_pulse;
    dev_reset_o ##1 !dev_reset_o;
  endsequence
  reset_pins_a: assert property ($rose(rstn_i) |-> (rts_n_o && dtr_n_o && irq_n_o)[*2])
    else $error("pins not inactive after power reset");
  push_follow_a: assert property (rx_push_o |-> $past(rx_valid_i) && rx_push_data_o == $past(rx_data_i))
    else $error("push without matching received character");
  push_none_a: assert property (!rx_valid_i |=> !rx_push_o)
    else $error("push with no character received");
  busy_hold_a: assert property (tx_shift_busy_i |-> !tx_start_ok_o)
    else $error("new character allowed while shifter busy");
  swrst_pulse_a: assert property (swrst_write |-> ##[1:2] reset_pulse)
    else $error("software reset not a single pulse");
  pin_reset_a: assert property ((!reset_pin_n_i)[*3] |-> dev_reset_o)
    else $error("pin reset not applied");
  divisor_keep_a: assert property (dev_reset_o |=> $stable(dl_low_o) && $stable(dl_high_o))
    else $error("divisor changed by reset");
  reset_outs_a: assert property (dev_reset_o[*3] |-> rts_n_o && dtr_n_o && irq_n_o)
    else $error("modem outputs active during reset");
  dtr_follow_a: assert property (dtr_write |-> ##[1:3] !dtr_n_o)
    else $error("data terminal ready did not follow control");
endmodule
bind uefr_core uefr_core_asserts u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
  .reset_pin_n_i(reset_pin_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
  .rx_push_o(rx_push_o), .rx_push_data_o(rx_push_data_o), .tx_shift_busy_i(tx_shift_busy_i),
  .tx_start_ok_o(tx_start_ok_o), .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o), .irq_n_o(irq_n_o),
  .dev_reset_o(dev_reset_o), .dl_low_o(dl_low_o), .dl_high_o(dl_high_o));
`default_nettype wire

// [verification/uefr_remote.sv]
// Remote serial device model: received characters and the clear-to-send level
`timescale 1ns/1ps
`default_nettype none
module uefr_remote (
  input wire logic clk_i,
  input wire logic send_i,
  input wire logic [7:0] char_i,
  input wire logic stall_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic cts_n_o
);
  // Known levels at time zero
  initial begin
    rx_valid_o = 1'h0;
    rx_data_o = 8'ha5;
    cts_n_o = 1'h0;
  end
  // One-cycle strobe; idle data toggles so a stale byte never looks valid
  always @(posedge clk_i) begin
    rx_valid_o <= send_i;
    rx_data_o <= send_i ? char_i : ~rx_data_o;
    cts_n_o <= stall_i;
  end
endmodule
`default_nettype wire

// [verification/test_uefr_core.sv]
// Self-checking bench for the enhanced feature control block
`timescale 1ns/1ps
`default_nettype none
module test_uefr_core;
  import uefr_pkg::*;
  typedef struct packed {logic wr; logic [4:0] a; logic [7:0] w; logic [7:0] e;} uefr_row_s;
  logic clk_i = 1'h0;
  logic rstn_i = 1'h0;
  logic pin_n = 1'h1, wr = 1'h0, rd = 1'h0, busy = 1'h0, modem_n = 1'h0;
  logic send = 1'h0, stall = 1'h0, rx_valid, cts_n, push, rts_n, dtr_n, irq_n, start_ok, dev_rst;
  logic [4:0] addr = 5'h00;
  logic [6:0] fill = 7'h00;
  logic [7:0] wdata = 8'h00, ch = 8'h00, rx_data, rdata, push_data, got, last_push = 8'h00;
  int n_fail = 0, compares = 0, n_push = 0, base = 0;
  // Power-up values, then gated writes before, during and after enabling
  uefr_row_s rows [] = '{'{1'h0, IDX_DLL, 8'h00, 8'h01}, '{1'h0, IDX_DLM, 8'h00, 8'h00},
    '{1'h0, IDX_SPR, 8'h00, 8'hff}, '{1'h0, IDX_TCR, 8'h00, 8'h0f}, '{1'h0, IDX_LCR, 8'h00, 8'h1d},
    '{1'h0, IDX_ISR, 8'h00, 8'h01}, '{1'h0, IDX_LSR, 8'h00, 8'h60}, '{1'h0, IDX_RES1, 8'h00, 8'h00},
    '{1'h1, IDX_TCR, 8'h55, 8'h0f}, '{1'h1, IDX_TLR, 8'h33, 8'h00}, '{1'h1, IDX_DLD, 8'h07, 8'h00},
    '{1'h1, IDX_IER, 8'hff, 8'h0f}, '{1'h1, IDX_SPR, 8'h5a, 8'h5a}, '{1'h1, IDX_DLL, 8'h34, 8'h34},
    '{1'h1, IDX_DLM, 8'h12, 8'h12}, '{1'h1, IDX_RES1, 8'h11, 8'h11}, '{1'h1, IDX_RES2, 8'h13, 8'h13},
    '{1'h1, IDX_STOP1, 8'h19, 8'h19}, '{1'h1, IDX_STOP2, 8'h5a, 8'h5a}, '{1'h1, IDX_EFR, 8'h10, 8'h10},
    '{1'h1, IDX_TCR, 8'h12, 8'h12}, '{1'h1, IDX_IER, 8'hf0, 8'hf0}, '{1'h1, IDX_DLD, 8'h07, 8'h07},
    '{1'h1, IDX_EFR, 8'h00, 8'h00}, '{1'h1, IDX_TCR, 8'h99, 8'h12}, '{1'h1, IDX_IER, 8'h00, 8'hf0},
    '{1'h1, IDX_DLD, 8'h03, 8'h07}};
  // Fill level in the upper bits, expected RTS level in bit 0
  logic [7:0] steps [4] = '{{7'h07, 1'h0}, {7'h08, 1'h1}, {7'h04, 1'h1}, {7'h03, 1'h0}};
  logic [7:0] modes [3] = '{8'h30, 8'h32, 8'h31};
  logic [7:0] flags [3] = '{8'h10, 8'h10, 8'h30};

  always #20 clk_i = ~clk_i;

  uefr_core u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .reset_pin_n_i(pin_n), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .rhr_data_i(8'h00),
    .lsr_i(8'h60), .tx_space_i(8'h40), .rx_fill_i(fill), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .rx_push_o(push), .rx_push_data_o(push_data), .thr_wr_o(), .thr_data_o(),
    .tx_shift_busy_i(busy), .tx_start_ok_o(start_ok), .cts_n_i(cts_n), .dsr_n_i(modem_n),
    .ri_n_i(modem_n), .cd_n_i(modem_n), .rts_n_o(rts_n), .dtr_n_o(dtr_n), .irq_n_o(irq_n),
    .dev_reset_o(dev_rst), .dl_low_o(), .dl_high_o(), .dl_frac_o(), .lcr_o(), .fcr_o(),
    .extra_feature_control_o(), .gpio_dir_o(), .gpio_out_o());
  uefr_remote u_remote (.clk_i(clk_i), .send_i(send), .char_i(ch), .stall_i(stall),
    .rx_valid_o(rx_valid), .rx_data_o(rx_data), .cts_n_o(cts_n));

  // Count pushes into the receive queue; sampled mid-cycle where the pulse is settled
  always @(negedge clk_i) begin
    if (push === 1'h1) begin
      n_push++;
      last_push = push_data;
    end
  end

  task automatic chk8(input string nm, input int id, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s %0h expected %h seen %h", nm, id, e, g);
    end
  endtask
  task automatic wreg(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr = a;
    wdata = d;
    wr = 1'h1;
    @(negedge clk_i);
    wr = 1'h0;
  endtask
  // Read data is registered, so it is taken one full cycle after the strobe
  task automatic rget(input logic [4:0] a);
    @(negedge clk_i);
    addr = a;
    rd = 1'h1;
    @(negedge clk_i);
    rd = 1'h0;
    @(negedge clk_i);
    got = rdata;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    rget(a);
    chk8("register", a, e, got);
  endtask
  task automatic rx_char(input logic [7:0] c);
    @(negedge clk_i);
    ch = c;
    send = 1'h1;
    @(negedge clk_i);
    send = 1'h0;
  endtask
  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs a few hundred cycles at most
  initial begin
    repeat (20000) @(negedge clk_i);
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (4) @(negedge clk_i);
    rstn_i = 1'h1;
    repeat (4) @(negedge clk_i);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wreg(rows[i].a, rows[i].w);
      end
      rchk(rows[i].a, rows[i].e);
    end
    // Software RTS first, then automatic halt and resume with hysteresis
    wreg(IDX_MCR, 8'h03);
    fill = 7'h3c;
    repeat (4) @(negedge clk_i);
    chk8("rts_n", 0, 8'h00, {7'h00, rts_n});
    fill = 7'h00;
    wreg(IDX_EFR, 8'h50);
    wreg(IDX_IER, 8'h01);
    foreach (steps[i]) begin
      fill = steps[i][7:1];
      repeat (4) @(negedge clk_i);
      chk8("rts_n", i, {7'h00, steps[i][0]}, {7'h00, rts_n});
    end
    fill = 7'h08;
    repeat (4) @(negedge clk_i);
    chk8("irq_n", 0, 8'h00, {7'h00, irq_n});
    fill = 7'h00;
    wreg(IDX_IER, 8'h00);
    // Clear-to-send gating and the busy shifter
    wreg(IDX_EFR, 8'h90);
    stall = 1'h1;
    repeat (6) @(negedge clk_i);
    chk8("start_ok", 0, 8'h00, {7'h00, start_ok});
    stall = 1'h0;
    repeat (6) @(negedge clk_i);
    chk8("start_ok", 1, 8'h01, {7'h00, start_ok});
    busy = 1'h1;
    @(negedge clk_i);
    chk8("start_ok", 2, 8'h00, {7'h00, start_ok});
    busy = 1'h0;
    // Special character in each compare mode; pair bits cleared between modes
    for (int k = 0; k < 3; k++) begin
      wreg(IDX_EFR, 8'h30);
      wreg(IDX_EFR, modes[k]);
      base = n_push;
      rx_char(8'h33);
      rx_char(8'h5a);
      repeat (4) @(negedge clk_i);
      chk8("pushes", k, (k < 2) ? 8'h02 : 8'h01, 8'(n_push - base));
      chk8("last push", k, (k < 2) ? 8'h5a : 8'h33, last_push);
      rget(IDX_ISR);
      chk8("status flags", k, flags[k], got & 8'h30);
    end
    // Software reset clears itself and keeps the divisor
    wreg(IDX_IOCTL, 8'h08);
    repeat (3) @(negedge clk_i);
    rchk(IDX_IOCTL, 8'h00);
    rchk(IDX_TCR, 8'h0f);
    rchk(IDX_DLL, 8'h34);
    // Pin reset after the modem inputs moved
    modem_n = 1'h1;
    stall = 1'h1;
    repeat (6) @(negedge clk_i);
    pin_n = 1'h0;
    repeat (4) @(negedge clk_i);
    chk8("dev_reset", 0, 8'h01, {7'h00, dev_rst});
    pin_n = 1'h1;
    repeat (6) @(negedge clk_i);
    rchk(IDX_MSR, 8'h00);
    rchk(IDX_MCR, 8'h00);
    rchk(IDX_SPR, 8'h5a);
    rchk(IDX_STOP2, 8'h5a);
    // Second power-up reset in mid-run
    modem_n = 1'h0;
    stall = 1'h0;
    rstn_i = 1'h0;
    repeat (5) @(negedge clk_i);
    rstn_i = 1'h1;
    repeat (4) @(negedge clk_i);
    rchk(IDX_DLL, 8'h01);
    rchk(IDX_SPR, 8'hff);
    rchk(IDX_STOP2, 8'h00);
    rchk(IDX_MSR, 8'hf0);
    print_verdict();
  end
endmodule
`default_nettype wire
